// ### src/sod_cfg_if.sv
// carrier between strap sampler, host strobe decoder and top
`timescale 1ns/1ps
`default_nettype none
interface sod_cfg_if;
  import sod_pkg::*;
  sod_strap_s strap;
  sod_live_s live;
  logic cfg_valid;
  logic host_en, mux_en, ale_pol, cpu_style, strobe_pol, wide16, swap, late_rd;
  logic host_wr, host_rd, hi_lane;
  logic [5:0] host_addr;
  modport sampler(output strap, live, cfg_valid);
  modport host(input live, host_en, mux_en, ale_pol, cpu_style, strobe_pol, wide16, swap,
    late_rd, output host_wr, host_rd, hi_lane, host_addr);
  modport top(input strap, live, cfg_valid, host_wr, host_rd, hi_lane, host_addr,
    output host_en, mux_en, ale_pol, cpu_style, strobe_pol, wide16, swap, late_rd);
endinterface
`default_nettype wire

// ### src/sod_defines.svh
// constants for the strap option decoder
`ifndef SOD_DEFINES_SVH
`define SOD_DEFINES_SVH
`define SOD_CLK_MHZ 40
`define SOD_PRIO_UNIT_US 146
`define SOD_PRIO_UNIT_CYC (`SOD_PRIO_UNIT_US * `SOD_CLK_MHZ)
`define SOD_PRIO_CNT_W 13
`define SOD_INIT_SOURCE_SELECT_BIT 9
`define SOD_ERRHALT_BIT 12
`define SOD_TOP_ID_MAX 5'h1F
`define SOD_FIRST_ID 5'h01
`define SOD_DIV_BASE 9'h008
`define SOD_RATE_FAST 3'h0
`define SOD_RATE_RSVD 3'h6
`define SOD_PAGE_BASE 9'h100
`define SOD_NODE_BASE 6'h04
`define SOD_BUF_BYTES 16'h0400
`endif

// ### src/sod_host_strobe.sv
// host bus strobe, address latch and byte lane decode
`timescale 1ns/1ps
`default_nettype none
module sod_host_strobe (
  input wire logic clk_in,
  input wire logic resetn_in,
  sod_cfg_if.host bus
);
  logic ds_act, wr_act, rd_act, ale_edge;
  logic [5:0] a_raw;
  logic wr_q, rd_q, rd_pend_q, ale_q;
  logic [5:0] lat_q;
  assign ds_act = bus.strobe_pol ? ~bus.live.rd_n : bus.live.rd_n;
  // in data strobe style the write pin carries the direction
  assign wr_act = bus.host_en & ~bus.live.cs_n &
    (bus.cpu_style ? (ds_act & ~bus.live.wr_n) : ~bus.live.wr_n);
  assign rd_act = bus.host_en & ~bus.live.cs_n &
    (bus.cpu_style ? (ds_act & bus.live.wr_n) : ~bus.live.rd_n);
  assign ale_edge = bus.ale_pol ? (ale_q & ~bus.live.ale) : (~ale_q & bus.live.ale);
  assign a_raw = bus.mux_en ? lat_q : bus.live.addr;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ale_q <= 1'b0;
      lat_q <= 6'h00;
    end else begin
      ale_q <= bus.live.ale;
      if (bus.mux_en && ale_edge) begin
        lat_q <= bus.live.data;
      end
    end
  end
  // write taken at the end of the access, whichever of select or strobe ends first
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd_pend_q <= 1'b0;
      bus.host_wr <= 1'b0;
      bus.host_rd <= 1'b0;
      bus.host_addr <= 6'h00;
      bus.hi_lane <= 1'b0;
    end else begin
      wr_q <= wr_act;
      rd_q <= rd_act;
      bus.host_wr <= wr_q & ~wr_act;
      rd_pend_q <= rd_act & ~rd_q & ~bus.late_rd;
      // hosts without late address timing get one more cycle before the read is taken
      bus.host_rd <= bus.late_rd ? (rd_act & ~rd_q) : rd_pend_q;
      bus.host_addr <= bus.wide16 ? {a_raw[5:1], 1'b0} : a_raw;
      bus.hi_lane <= ~bus.wide16 & (a_raw[0] ^ bus.swap);
    end
  end
endmodule
`default_nettype wire

// ### src/sod_pkg.sv
// types shared by the strap option decoder modules
package sod_pkg;
  typedef struct packed {
    logic standalone_n;
    logic mux_n;
    logic ale_pol;
    logic cpu_style;
    logic wide;
    logic swap;
    logic strobe_pol;
    logic late_wr;
    logic late_rd;
    logic carry3;
    logic carry0;
    logic [1:0] page;
    logic [4:0] top_id;
    logic [4:0] own_id;
    logic diag_n;
    logic [2:0] rate;
    logic bypass_n;
    logic hub_n;
    logic optical_n;
    logic tx_pol;
    logic scm4;
  } sod_strap_s;
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic ale;
    logic [5:0] addr;
    logic [5:0] data;
    logic rx2;
  } sod_live_s;
endpackage

// ### src/sod_strap_decoder.sv
// strap option decoder top: strap capture, option decode, node and rate logic
//
// Overview of operation
// - peripheral mode, mux strap low puts address on data bits 5..0.
// - multiplexed bus latches address on latch strobe edge chosen by polarity strap.
// - standalone mode reads mux, style, wide, byte order, chip select straps as master id bits.
// - style strap high uses data strobe plus direction, low separate strobes.
// - wide strap picks 16-bit bus with address bit 0 forced zero.
// - byte order strap low maps low byte to even addresses.
// - peripheral mode, polarity strap high makes data strobe active low.
// - standalone, polarity strap is error halt; corrected error stops reception.
// - page codes give 256/128/64/32 byte pages, 3/7/15/31 nodes.
// - init source bit 9 picks page, top id, prescaler from straps or inputs.
// - own node id source follows the same init source bit.
// - diagnostic strap low forces top node id to its largest value.
// - token passes only up to top id; top id node starts it.
// - priority timer lasts (top minus own) times 146 us, halved at fastest rate.
// - prescale codes 000..101 divide clock by 8..256; 110 and 111 reserved.
// - standalone, four carry digit straps give the time carry digit.
// - line code bypass strap low selects return-to-zero interface.
// - hub strap low enables hub and second port; high ignores port two.
// - optical strap low adds pulses to transmit enables; polarity strap chosen.
`timescale 1ns/1ps
`default_nettype none
`include "sod_defines.svh"
module sod_strap_decoder
  import sod_pkg::*;
#(
  parameter int unsigned PRIO_UNIT_CYC = `SOD_PRIO_UNIT_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic standalone_select_n_in,
  input wire logic addr_mux_select_n_in,
  input wire logic latch_edge_polarity_in,
  input wire logic cpu_style_select_in,
  input wire logic wide_bus_select_in,
  input wire logic byte_order_select_in,
  input wire logic strobe_polarity_select_in,
  input wire logic late_write_timing_select_in,
  input wire logic late_read_timing_select_in,
  input wire logic carry_digit3_in,
  input wire logic carry_digit0_in,
  input wire logic [1:0] page_size_select_in,
  input wire logic [4:0] top_node_id_in,
  input wire logic [4:0] own_node_id_in,
  input wire logic diagnostic_select_n_in,
  input wire logic [2:0] rate_prescale_select_in,
  input wire logic line_code_bypass_n_in,
  input wire logic hub_enable_n_in,
  input wire logic optical_mode_select_n_in,
  input wire logic tx_enable_polarity_in,
  input wire logic chip_select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic read_strobe_n_in,
  input wire logic ale_in,
  input wire logic [5:0] addr_in,
  input wire logic [5:0] data_in,
  input wire logic port2_rx_in,
  input wire logic [15:0] reg_mode_in,
  input wire logic [1:0] reg_page_size_in,
  input wire logic [4:0] reg_top_node_id_in,
  input wire logic [4:0] reg_own_node_id_in,
  input wire logic [2:0] reg_rate_prescale_in,
  input wire logic reconfig_start_in,
  input wire logic tx_request_in,
  input wire logic tx_pulse_in,
  input wire logic line_error_corrected_in,
  output logic cfg_valid_out,
  output logic standalone_out,
  output logic [4:0] clock_master_id_out,
  output logic late_write_timing_out,
  output logic error_halt_mode_out,
  output logic [8:0] page_size_bytes_out,
  output logic [4:0] max_nodes_out,
  output logic [4:0] top_node_id_out,
  output logic [4:0] own_node_id_out,
  output logic node_id_valid_out,
  output logic token_initiator_out,
  output logic [4:0] next_node_id_out,
  output logic [8:0] prescale_div_out,
  output logic rate_reserved_out,
  output logic rate_tick_out,
  output logic reconfig_busy_out,
  output logic reconfig_timeout_out,
  output logic [3:0] carry_digit_out,
  output logic line_code_bypass_out,
  output logic hub_on_out,
  output logic port2_rx_out,
  output logic port1_tx_enable_out,
  output logic port2_tx_enable_out,
  output logic rx_stop_out,
  output logic host_write_out,
  output logic host_read_out,
  output logic [5:0] host_addr_out,
  output logic host_hi_lane_out
);
  // ****************************************
  // strap capture and host strobe decode
  // ****************************************
  sod_cfg_if bus();
  sod_strap_s pins;
  sod_strap_s s;
  sod_live_s live;
  assign pins = '{standalone_n: standalone_select_n_in, mux_n: addr_mux_select_n_in,
    ale_pol: latch_edge_polarity_in, cpu_style: cpu_style_select_in,
    wide: wide_bus_select_in, swap: byte_order_select_in,
    strobe_pol: strobe_polarity_select_in, late_wr: late_write_timing_select_in,
    late_rd: late_read_timing_select_in, carry3: carry_digit3_in,
    carry0: carry_digit0_in, page: page_size_select_in, top_id: top_node_id_in,
    own_id: own_node_id_in, diag_n: diagnostic_select_n_in,
    rate: rate_prescale_select_in, bypass_n: line_code_bypass_n_in,
    hub_n: hub_enable_n_in, optical_n: optical_mode_select_n_in,
    tx_pol: tx_enable_polarity_in, scm4: chip_select_n_in};
  assign live = '{cs_n: chip_select_n_in, wr_n: write_strobe_n_in,
    rd_n: read_strobe_n_in, ale: ale_in, addr: addr_in, data: data_in,
    rx2: port2_rx_in};
  sod_strap_sampler u_sampler (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .strap_pins_in(pins),
    .live_pins_in(live),
    .bus(bus.sampler)
  );
  sod_host_strobe u_host (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .bus(bus.host)
  );
  assign s = bus.strap;

  // ****************************************
  // option source selection
  // ****************************************
  logic init_reg, stand, fast;
  logic [1:0] ps_sel;
  logic [2:0] rate_sel;
  logic [4:0] top_src, top_eff, own_sel, diff;
  logic [8:0] div_sel;
  assign init_reg = reg_mode_in[`SOD_INIT_SOURCE_SELECT_BIT];
  assign stand = ~s.standalone_n;
  assign ps_sel = init_reg ? reg_page_size_in : s.page;
  assign rate_sel = init_reg ? reg_rate_prescale_in : s.rate;
  assign top_src = init_reg ? reg_top_node_id_in : s.top_id;
  assign top_eff = s.diag_n ? top_src : `SOD_TOP_ID_MAX;
  assign own_sel = init_reg ? reg_own_node_id_in : s.own_id;
  assign div_sel = `SOD_DIV_BASE << rate_sel;
  assign fast = (rate_sel == `SOD_RATE_FAST);
  assign diff = (own_sel <= top_eff) ? top_eff - own_sel : 5'h00;

  // host side options; standalone mode keeps the host decoder idle
  assign bus.host_en = bus.cfg_valid & ~stand;
  assign bus.mux_en = ~s.mux_n;
  assign bus.ale_pol = s.ale_pol;
  assign bus.cpu_style = s.cpu_style;
  assign bus.strobe_pol = s.strobe_pol;
  assign bus.wide16 = s.wide;
  assign bus.swap = s.swap;
  assign bus.late_rd = s.late_rd;

  // ****************************************
  // decoded mode outputs
  // ****************************************
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_valid_out <= 1'b0;
      standalone_out <= 1'b0;
      clock_master_id_out <= 5'h00;
      late_write_timing_out <= 1'b0;
      error_halt_mode_out <= 1'b0;
      carry_digit_out <= 4'h0;
      line_code_bypass_out <= 1'b0;
      hub_on_out <= 1'b0;
    end else if (bus.cfg_valid) begin
      cfg_valid_out <= 1'b1;
      standalone_out <= stand;
      clock_master_id_out <= stand ? {s.scm4, s.swap, s.wide, s.cpu_style, s.mux_n}
        : 5'h00;
      late_write_timing_out <= s.late_wr;
      error_halt_mode_out <= stand ? s.strobe_pol : reg_mode_in[`SOD_ERRHALT_BIT];
      carry_digit_out <= stand ? {s.carry3, s.late_wr, s.late_rd, s.carry0} : 4'h0;
      line_code_bypass_out <= ~s.bypass_n;
      hub_on_out <= ~s.hub_n;
    end
  end

  // ****************************************
  // page, node and ring decode
  // ****************************************
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      page_size_bytes_out <= 9'h000;
      max_nodes_out <= 5'h00;
      top_node_id_out <= 5'h00;
      own_node_id_out <= 5'h00;
      node_id_valid_out <= 1'b0;
      token_initiator_out <= 1'b0;
      next_node_id_out <= 5'h00;
      prescale_div_out <= 9'h000;
      rate_reserved_out <= 1'b0;
    end else if (bus.cfg_valid) begin
      page_size_bytes_out <= `SOD_PAGE_BASE >> ps_sel;
      max_nodes_out <= 5'((`SOD_NODE_BASE << ps_sel) - 6'h01);
      top_node_id_out <= top_eff;
      own_node_id_out <= own_sel;
      // invalid ids are flagged, not corrected
      node_id_valid_out <= (own_sel != 5'h00) && (own_sel <= top_eff);
      token_initiator_out <= (own_sel == top_eff);
      next_node_id_out <= (own_sel >= top_eff) ? `SOD_FIRST_ID : own_sel + 5'h01;
      rate_reserved_out <= (rate_sel >= `SOD_RATE_RSVD);
      prescale_div_out <= (rate_sel >= `SOD_RATE_RSVD) ? 9'h000 : div_sel;
    end
  end

  // ****************************************
  // bit rate tick
  // ****************************************
  logic [8:0] tick_cnt_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_cnt_q <= 9'h000;
      rate_tick_out <= 1'b0;
    end else if (!bus.cfg_valid || rate_sel >= `SOD_RATE_RSVD) begin
      tick_cnt_q <= 9'h000;
      rate_tick_out <= 1'b0;
    end else if (tick_cnt_q >= div_sel - 9'h001) begin
      tick_cnt_q <= 9'h000;
      rate_tick_out <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 9'h001;
      rate_tick_out <= 1'b0;
    end
  end

  // ****************************************
  // reconfiguration priority timer
  // ****************************************
  localparam int unsigned HALF_CYC = PRIO_UNIT_CYC / 2;
  logic [`SOD_PRIO_CNT_W-1:0] unit_len, unit_q;
  logic [4:0] mult_q;
  // the unit is fixed at start so a rate change mid-wait cannot stretch it
  logic [`SOD_PRIO_CNT_W-1:0] unit_len_q;
  assign unit_len = fast ? `SOD_PRIO_CNT_W'(HALF_CYC) : `SOD_PRIO_CNT_W'(PRIO_UNIT_CYC);
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reconfig_busy_out <= 1'b0;
      reconfig_timeout_out <= 1'b0;
      unit_q <= '0;
      unit_len_q <= '0;
      mult_q <= 5'h00;
    end else begin
      reconfig_timeout_out <= 1'b0;
      if (reconfig_start_in && bus.cfg_valid) begin
        reconfig_busy_out <= 1'b1;
        unit_q <= '0;
        unit_len_q <= unit_len;
        mult_q <= diff;
      end else if (reconfig_busy_out) begin
        if (mult_q == 5'h00) begin
          reconfig_busy_out <= 1'b0;
          reconfig_timeout_out <= 1'b1;
        end else if (unit_q == unit_len_q - 1'b1) begin
          unit_q <= '0;
          mult_q <= mult_q - 5'h01;
        end else begin
          unit_q <= unit_q + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // line side: second port, transmit enables, receive halt
  // ****************************************
  logic en1, en2;
  // pulses ride on the enables only for a direct optical drive
  assign en1 = s.optical_n ? tx_request_in : tx_request_in & tx_pulse_in;
  assign en2 = en1 & ~s.hub_n;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port2_rx_out <= 1'b1;
      port1_tx_enable_out <= 1'b0;
      port2_tx_enable_out <= 1'b0;
      rx_stop_out <= 1'b0;
    end else if (bus.cfg_valid) begin
      port2_rx_out <= s.hub_n | bus.live.rx2;
      port1_tx_enable_out <= s.tx_pol ? en1 : ~en1;
      port2_tx_enable_out <= s.tx_pol ? en2 : ~en2;
      rx_stop_out <= line_error_corrected_in & error_halt_mode_out;
    end
  end

  assign host_write_out = bus.host_wr;
  assign host_read_out = bus.host_rd;
  assign host_addr_out = bus.host_addr;
  assign host_hi_lane_out = bus.hi_lane;

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [17:0] prio_seen_q, prio_exp_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prio_seen_q <= '0;
      prio_exp_q <= '0;
    end else if (reconfig_start_in && bus.cfg_valid) begin
      prio_seen_q <= '0;
      prio_exp_q <= 18'(diff) * 18'(unit_len) + 18'h00001;
    end else if (reconfig_busy_out) begin
      prio_seen_q <= prio_seen_q + 18'h00001;
    end
  end
  a_strap_hold: assert property (bus.cfg_valid |=> $stable(bus.strap))
    else $error("straps changed after capture");
  a_diag_top_max: assert property ((bus.cfg_valid && !s.diag_n) |=>
    top_node_id_out == `SOD_TOP_ID_MAX)
    else $error("diagnostic strap did not force top id");
  a_init_reg_src: assert property ((bus.cfg_valid && init_reg && s.diag_n) |=>
    top_node_id_out == $past(reg_top_node_id_in) && own_node_id_out == $past(reg_own_node_id_in))
    else $error("register source not applied");
  a_own_id_strap: assert property ((bus.cfg_valid && !init_reg) |=>
    own_node_id_out == s.own_id)
    else $error("own id not from strap");
  a_page_fits_buf: assert property (cfg_valid_out |->
    16'(page_size_bytes_out) * (16'(max_nodes_out) + 16'h0001) == `SOD_BUF_BYTES)
    else $error("page size and node count disagree");
  a_ring_wraps: assert property (token_initiator_out |-> next_node_id_out == `SOD_FIRST_ID)
    else $error("initiator does not wrap the ring");
  a_prio_length: assert property (reconfig_timeout_out |-> prio_seen_q == prio_exp_q)
    else $error("priority timer length wrong");
  a_tick_spacing: assert property ((rate_tick_out && !rate_reserved_out) |=>
    !rate_tick_out [*7])
    else $error("rate tick too close");
  a_rsvd_silent: assert property (rate_reserved_out |-> !rate_tick_out)
    else $error("tick in reserved rate");
  a_stand_cmid: assert property ((bus.cfg_valid && stand) |=>
    clock_master_id_out[2] == s.wide && clock_master_id_out[3] == s.swap)
    else $error("standalone master id wrong");
  a_err_halt_stop: assert property ((bus.cfg_valid && line_error_corrected_in &&
    error_halt_mode_out) |=> rx_stop_out)
    else $error("corrected error did not stop reception");
  a_wide_lsb: assert property ((bus.cfg_valid && s.wide) |=> ##1 !host_addr_out[0])
    else $error("wide bus address bit 0 not zero");
  a_hub_off_tx2: assert property ((cfg_valid_out && !hub_on_out) |=>
    port2_tx_enable_out == !s.tx_pol && port2_rx_out)
    else $error("second port active with hub off");
  a_bypass_map: assert property (bus.cfg_valid |=> line_code_bypass_out == !s.bypass_n)
    else $error("bypass strap not decoded");
  c_timeout: cover property (reconfig_busy_out ##1 reconfig_timeout_out);
  c_initiator: cover property (token_initiator_out && node_id_valid_out);
  c_host_write: cover property (host_write_out);
  c_host_read: cover property (host_read_out && host_hi_lane_out);
endmodule
`default_nettype wire

// ### src/sod_strap_sampler.sv
// pin synchronisers and one-time strap capture
`timescale 1ns/1ps
`default_nettype none
module sod_strap_sampler
  import sod_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire sod_strap_s strap_pins_in,
  input wire sod_live_s live_pins_in,
  sod_cfg_if.sampler bus
);
  sod_strap_s s1_q, s2_q;
  sod_live_s l1_q, l2_q;
  logic loaded_q;
  // idle pin levels, so no strobe or latch edge is seen as reset lifts
  localparam sod_live_s LIVE_IDLE = '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, ale: 1'b0,
    addr: 6'h00, data: 6'h00, rx2: 1'b1};
  // no reset here so the chain tracks the straps while reset is held
  always_ff @(posedge clk_in) begin
    s1_q <= strap_pins_in;
    s2_q <= s1_q;
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      l1_q <= LIVE_IDLE;
      l2_q <= LIVE_IDLE;
    end else begin
      l1_q <= live_pins_in;
      l2_q <= l1_q;
    end
  end
  // straps taken once, at the first edge after release
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus.strap <= '0;
      loaded_q <= 1'b0;
    end else if (!loaded_q) begin
      bus.strap <= s2_q;
      loaded_q <= 1'b1;
    end
  end
  assign bus.cfg_valid = loaded_q;
  assign bus.live = l2_q;
endmodule
`default_nettype wire

// ### verification/sod_host_model.sv
// host side model: write and read-back cycles on the host bus
`timescale 1ns/1ps
`default_nettype none
module sod_host_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic late_wr_in,
  input wire logic [5:0] addr_in,
  output logic cs_n_out,
  output logic wr_n_out,
  output logic rd_n_out,
  output logic [5:0] addr_out
);
  // ****************
  // write and read-back access
  // ****************
  initial begin
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    addr_out = 6'h2A;
  end
  always begin
    @(posedge clk_in iff go_in);
    @(negedge clk_in);
    {cs_n_out, wr_n_out} = 2'b00;
    addr_out = addr_in;
    repeat (4) @(negedge clk_in);
    // which strobe ends first depends on the host type
    {cs_n_out, wr_n_out} = late_wr_in ? 2'b10 : 2'b01;
    @(negedge clk_in);
    {cs_n_out, wr_n_out} = 2'b11;
    // read back the same address, presented ahead of select and strobe
    repeat (2) @(negedge clk_in);
    {cs_n_out, rd_n_out} = 2'b00;
    repeat (3) @(negedge clk_in);
    {cs_n_out, rd_n_out} = 2'b11;
    // address dropped only once the read strobe is gone
    addr_out = ~addr_out;
  end
endmodule
`default_nettype wire

// ### verification/strap_option_decoder_bench.sv
// self-checking bench for the strap option decoder
`timescale 1ns/1ps
`default_nettype none
module strap_option_decoder_bench;
  logic clk_in = 1'b0, resetn_in = 1'b0, go;
  logic standalone_select_n_in, addr_mux_select_n_in, latch_edge_polarity_in;
  logic cpu_style_select_in, wide_bus_select_in, byte_order_select_in;
  logic strobe_polarity_select_in, late_write_timing_select_in, late_read_timing_select_in;
  logic carry_digit3_in, carry_digit0_in, diagnostic_select_n_in, line_code_bypass_n_in;
  logic hub_enable_n_in, optical_mode_select_n_in, tx_enable_polarity_in, chip_select_n_in;
  logic write_strobe_n_in, read_strobe_n_in, ale_in = 1'b0, port2_rx_in = 1'b1;
  logic reconfig_start_in, tx_request_in, tx_pulse_in, line_error_corrected_in;
  logic [1:0] page_size_select_in, reg_page_size_in;
  logic [4:0] top_node_id_in, own_node_id_in, reg_top_node_id_in, reg_own_node_id_in;
  logic [2:0] rate_prescale_select_in, reg_rate_prescale_in;
  logic [5:0] addr_in, data_in, host_addr_out, wa;
  logic [15:0] reg_mode_in, q[$];
  logic cfg_valid_out, standalone_out, late_write_timing_out, error_halt_mode_out;
  logic node_id_valid_out, token_initiator_out, rate_reserved_out, rate_tick_out;
  logic reconfig_busy_out, reconfig_timeout_out, line_code_bypass_out, hub_on_out;
  logic port2_rx_out, port1_tx_enable_out, port2_tx_enable_out, rx_stop_out;
  logic host_write_out, host_read_out, host_hi_lane_out;
  logic [4:0] clock_master_id_out, max_nodes_out, top_node_id_out, own_node_id_out;
  logic [4:0] next_node_id_out;
  logic [8:0] page_size_bytes_out, prescale_div_out;
  logic [3:0] carry_digit_out;
  int n_errors = 0, checks_done = 0, cyc = 0;
  logic [31:0] seed = 32'hB72B5967;
  always #12.5 clk_in = ~clk_in;
  // short priority unit keeps the timer runs brief
  sod_strap_decoder #(.PRIO_UNIT_CYC(8)) u_sod_strap_decoder (.*);
  sod_host_model u_sod_host_model (.clk_in, .go_in(go), .late_wr_in(late_write_timing_select_in),
    .addr_in(wa), .cs_n_out(chip_select_n_in), .wr_n_out(write_strobe_n_in),
    .rd_n_out(read_strobe_n_in), .addr_out(addr_in));
  // ****************
  // checking
  // ****************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // pulses are matched in order against the notes left by the drivers
  always @(negedge clk_in) begin
    if (resetn_in && (host_write_out | host_read_out | reconfig_timeout_out |
        rx_stop_out) === 1'b1) begin
      if (q.size() == 0) chk(16'hFFFF, 16'h0000, "stray pulse");
      else chk(host_write_out | host_read_out ? {9'h000, host_hi_lane_out, host_addr_out}
        : reconfig_timeout_out ? cyc[15:0] : 16'h00E0,
        q.pop_front(), "pulse");
    end
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  // ****************
  // stimulus
  // ****************
  task automatic boot(input logic sa);
    resetn_in = 1'b0;
    {standalone_select_n_in, diagnostic_select_n_in, strobe_polarity_select_in} = {~sa, ~sa, sa};
    {addr_mux_select_n_in, latch_edge_polarity_in, cpu_style_select_in, wide_bus_select_in} =
      {3'b100, sa};
    {byte_order_select_in, late_write_timing_select_in, late_read_timing_select_in} = {~sa, 2'b01};
    {carry_digit3_in, carry_digit0_in, hub_enable_n_in, optical_mode_select_n_in} = {2'b10, sa, ~sa};
    {line_code_bypass_n_in, tx_enable_polarity_in, page_size_select_in} = {1'b0, ~sa, 2'b10};
    {top_node_id_in, own_node_id_in, rate_prescale_select_in} = 13'h0518;
    reg_mode_in = 16'h0000;
    repeat (16) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic tx_run;
    logic [1:0] p;
    p = {tx_request_in, tx_pulse_in};
    repeat (12) begin
      @(negedge clk_in);
      chk(port1_tx_enable_out, (p[1] & (optical_mode_select_n_in | p[0])) ^ !tx_enable_polarity_in,
        "tx1");
      if (!hub_enable_n_in) chk(port2_tx_enable_out, p[1] ^ !tx_enable_polarity_in, "tx2");
      p = 2'($random(seed));
      {tx_request_in, tx_pulse_in} = p;
    end
  endtask
  task automatic host_wr;
    repeat (3) begin
      wa = 6'($random(seed));
      data_in = 6'($random(seed));
      if (standalone_select_n_in) repeat (2) // write, then read back
        q.push_back({9'h000, wa[0] ^ byte_order_select_in, wa});
      go = 1'b1;
      @(negedge clk_in);
      go = 1'b0;
      repeat (16) @(negedge clk_in);
    end
  endtask
  task automatic err_pulse;
    if (error_halt_mode_out === 1'b1) q.push_back(16'h00E0);
    line_error_corrected_in = 1'b1;
    @(negedge clk_in);
    line_error_corrected_in = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  initial begin
    {go, reconfig_start_in, tx_request_in, tx_pulse_in, line_error_corrected_in} = 5'h00;
    {reg_page_size_in, reg_top_node_id_in, reg_own_node_id_in, reg_rate_prescale_in} = 15'h671D;
    {data_in, wa} = 12'h000;
    boot(1'b0);
    chk(page_size_bytes_out, 16'h0040, "page");
    chk(max_nodes_out, 16'h000F, "nodes");
    chk({top_node_id_out, own_node_id_out}, 16'h00A3, "ids");
    chk({clock_master_id_out, carry_digit_out}, 16'h0000, "sa fields");
    chk({line_code_bypass_out, hub_on_out, token_initiator_out}, 16'h0006, "line");
    chk({cfg_valid_out, standalone_out, node_id_valid_out, late_write_timing_out,
      next_node_id_out}, 16'h0144, "node");
    tx_run();
    host_wr();
    err_pulse();
    reg_mode_in = 16'h0200;
    for (int i = 0; i < 8; i++) begin
      reg_rate_prescale_in = 3'(i);
      repeat (2) @(negedge clk_in);
      chk(prescale_div_out, i < 6 ? 16'h0008 << i : 16'h0000, "div");
      chk(rate_reserved_out, 16'(i > 5), "rsvd");
    end
    chk({max_nodes_out, top_node_id_out}, 16'h03E7, "override");
    reg_rate_prescale_in = 3'h0;
    foreach (reg_own_node_id_in[i]) begin
      // diff 4 first, then own equals top: zero wait and initiator
      q.push_back(16'(cyc + (i == 4 ? 18 : 2)));
      reconfig_start_in = 1'b1;
      @(negedge clk_in);
      reconfig_start_in = 1'b0;
      chk(reconfig_busy_out, 16'h0001, "busy");
      repeat (24) @(negedge clk_in);
      reg_own_node_id_in = 5'h07;
      if (i == 3) break;
    end
    chk(token_initiator_out, 16'h0001, "initiator");
    {reg_mode_in, top_node_id_in, page_size_select_in} = 23'h0;
    repeat (3) @(negedge clk_in);
    chk({page_size_bytes_out, top_node_id_out}, 16'h0805, "held straps");
    boot(1'b1);
    chk({clock_master_id_out, carry_digit_out}, 16'h015A, "sa fields");
    chk({top_node_id_out, error_halt_mode_out}, 16'h003F, "diag");
    chk({hub_on_out, port2_rx_out}, 16'h0001, "hub off");
    tx_run();
    host_wr();
    err_pulse();
    chk(16'(q.size()), 16'h0000, "pending");
    close_out();
  end
endmodule
`default_nettype wire
